// ---- rtca_map.vh ----
// Purpose: Register offsets, field positions and reset values of the alarm and countdown slice.
// Assumes: Byte-wide registers addressed by an 8-bit register index.
// Notes:   Definitions only.
`ifndef RTCA_MAP_VH
`define RTCA_MAP_VH

// ==========================================================================
// Register offsets
`define RTCA_OFS_A1_SEC      8'h0F
`define RTCA_OFS_A1_MIN      8'h10
`define RTCA_OFS_A1_HOURS    8'h11
`define RTCA_OFS_A1_DAYDATE  8'h12
`define RTCA_OFS_A1_MONTH    8'h13
`define RTCA_OFS_A1_YEAR     8'h14
`define RTCA_OFS_A2_MIN      8'h15
`define RTCA_OFS_A2_HOURS    8'h16
`define RTCA_OFS_A2_DAYDATE  8'h17
`define RTCA_OFS_CNT_VALUE   8'h18
`define RTCA_OFS_CNT_RELOAD  8'h19

// ==========================================================================
// Field positions
`define RTCA_BIT_IGNORE      7
`define RTCA_BIT_WEEKDAY     6
`define RTCA_BIT_YEAR_IGN    6
`define RTCA_BIT_PM_TWENTY   5
`define RTCA_BIT_HR_TENS     4
`define RTCA_BIT_MON_TENS    4

// Writable bits per register; unused bits read as zero.
`define RTCA_WMASK_FULL      8'hFF
`define RTCA_WMASK_HOURS     8'hBF
`define RTCA_WMASK_MONTH     8'hDF

// ==========================================================================
// Reset values
`define RTCA_RST_ALARM       8'h00
`define RTCA_RST_COUNT       8'h00
`define RTCA_RST_RELOAD      8'h00

`endif

// ---- rtca_field_cmp.v ----
// Purpose: One maskable compare of an alarm field against the running time.
// Assumes: Both operands are aligned to the same bits.
// Notes:   An ignored field always counts as matching.
`timescale 1ns/10ps
`default_nettype none
module rtca_field_cmp #(
  parameter W = 8
) (
  input  wire [W-1:0] alarm_val,  // Stored alarm field
  input  wire [W-1:0] time_val,   // Current time field
  input  wire         ignore,     // Field left out of the compare
  output wire         hit         // Field satisfied
);
  assign hit = ignore | (alarm_val == time_val);
endmodule
`default_nettype wire

// ---- rtca_regs.v ----
// Purpose: Alarm compare registers for two alarms and the countdown value/reload pair.
// Assumes: One clock; the register port is a byte-wide strobe interface from the serial slave.
// Notes:   Alarm outputs are one-cycle pulses on the rising edge of a full match.
`timescale 1ns/10ps
`default_nettype none
`include "rtca_map.vh"

// Functional notes
// - Alarm1 minutes keeps its ignore bit in 7, minute tens in 6:4 and minute units in 3:0.
// - Alarm1 hours keeps its ignore bit in 7, hour tens in 4, units in 3:0 and bit 6 unused.
// - Alarm1 hours bit 5 means PM in 12-hour coding and twenty hours in 24-hour coding.
// - Alarm1 day/date keeps its ignore bit in 7, date tens in 5:4 and units in 3:0.
// - Bit 6 of each day/date register picks date compare at 0 and weekday compare at 1.
// - Alarm1 month keeps the month ignore bit in 7 and the year ignore bit in 6.
// - Alarm1 month keeps month tens in bit 4 and units in 3:0 with bit 5 unused.
// - Alarm1 year keeps year tens in 7:4 and year units in 3:0 with no ignore bit.
// - Alarm2 minutes keeps its ignore bit in 7, tens in 6:4 and units in 3:0.
// - Alarm2 hours keeps ignore in 7, PM/twenty in 5, tens in 4 and units in 3:0.
// - Alarm2 day/date keeps ignore in 7, weekday select in 6, tens in 5:4, units in 3:0.
// - The countdown value is an 8-bit read-only register resetting to zero.
// - A separate 8-bit reload register resets to zero.
// - All alarm bits reset to zero, which selects date matching.
// - In repeat mode a countdown reaching zero reloads from the reload register.
// - Alarm1 seconds keeps its ignore bit in 7 with seconds tens and units below.
module rtca_regs (
  input  wire       sys_clk,      // 40 MHz clock
  input  wire       arst_n,       // Asynchronous reset, active low
  input  wire [7:0] reg_addr,     // Register index
  input  wire [7:0] reg_wdata,    // Write data
  input  wire       reg_wr,       // Write strobe, one cycle
  input  wire       reg_rd,       // Read strobe, one cycle
  output reg  [7:0] reg_rdata_ff, // Read data, valid the cycle after reg_rd
  input  wire [6:0] time_sec,     // Current seconds, BCD
  input  wire [6:0] time_min,     // Current minutes, BCD
  input  wire [5:0] time_hour,    // Current hours with PM/twenty bit at 5
  input  wire [2:0] time_day,     // Current weekday
  input  wire [5:0] time_date,    // Current date, BCD
  input  wire [4:0] time_month,   // Current month, BCD
  input  wire [7:0] time_year,    // Current year, BCD
  input  wire       tick,         // Countdown tick, one cycle, same clock
  input  wire       cnt_enable,   // Countdown running
  input  wire       cnt_repeat,   // Reload on zero instead of stopping
  output reg        alarm1_ff,    // Alarm1 match pulse
  output reg        alarm2_ff,    // Alarm2 match pulse
  output reg        cnt_zero_ff   // Countdown reached zero pulse
);

  // ========================================================================
  // Register storage
  reg  [7:0] a1_sec_ff;
  reg  [7:0] a1_min_ff;
  reg  [7:0] a1_hours_ff;
  reg  [7:0] a1_daydate_ff;
  reg  [7:0] a1_month_ff;
  reg  [7:0] a1_year_ff;
  reg  [7:0] a2_min_ff;
  reg  [7:0] a2_hours_ff;
  reg  [7:0] a2_daydate_ff;
  reg  [7:0] cnt_value_ff;
  reg  [7:0] cnt_reload_ff;
  reg        a1_match_ff;
  reg        a2_match_ff;
  reg  [7:0] nxt_rdata;
  reg  [7:0] nxt_cnt;
  reg        nxt_zero;

  // Alarm1 storage.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      a1_sec_ff     <= `RTCA_RST_ALARM;
      a1_min_ff     <= `RTCA_RST_ALARM;
      a1_hours_ff   <= `RTCA_RST_ALARM;
      a1_daydate_ff <= `RTCA_RST_ALARM;
      a1_month_ff   <= `RTCA_RST_ALARM;
      a1_year_ff    <= `RTCA_RST_ALARM;
    end else if (reg_wr) begin
      case (reg_addr)
        `RTCA_OFS_A1_SEC:     a1_sec_ff     <= reg_wdata;
        `RTCA_OFS_A1_MIN:     a1_min_ff     <= reg_wdata;
        `RTCA_OFS_A1_HOURS:   a1_hours_ff   <= reg_wdata & `RTCA_WMASK_HOURS;
        `RTCA_OFS_A1_DAYDATE: a1_daydate_ff <= reg_wdata;
        `RTCA_OFS_A1_MONTH:   a1_month_ff   <= reg_wdata & `RTCA_WMASK_MONTH;
        `RTCA_OFS_A1_YEAR:    a1_year_ff    <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Alarm2 storage.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      a2_min_ff     <= `RTCA_RST_ALARM;
      a2_hours_ff   <= `RTCA_RST_ALARM;
      a2_daydate_ff <= `RTCA_RST_ALARM;
    end else if (reg_wr) begin
      case (reg_addr)
        `RTCA_OFS_A2_MIN:     a2_min_ff     <= reg_wdata;
        `RTCA_OFS_A2_HOURS:   a2_hours_ff   <= reg_wdata & `RTCA_WMASK_HOURS;
        `RTCA_OFS_A2_DAYDATE: a2_daydate_ff <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // Reload storage; the running count itself cannot be written from the bus.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reload_ff <= `RTCA_RST_RELOAD;
    end else if (reg_wr && (reg_addr == `RTCA_OFS_CNT_RELOAD)) begin
      cnt_reload_ff <= reg_wdata;
    end
  end

  // ========================================================================
  // Field view
  // Named views of the stored bits keep the compares below readable.
  wire       first_alarm_sec_ignore      = a1_sec_ff[`RTCA_BIT_IGNORE];
  wire       first_alarm_min_ignore      = a1_min_ff[`RTCA_BIT_IGNORE];
  wire       first_alarm_hr_ignore       = a1_hours_ff[`RTCA_BIT_IGNORE];
  wire       first_alarm_pm_or_twenty    = a1_hours_ff[`RTCA_BIT_PM_TWENTY];
  wire       first_alarm_daydate_ignore  = a1_daydate_ff[`RTCA_BIT_IGNORE];
  wire       first_alarm_weekday_select  = a1_daydate_ff[`RTCA_BIT_WEEKDAY];
  wire       first_alarm_month_ignore    = a1_month_ff[`RTCA_BIT_IGNORE];
  wire       first_alarm_year_ignore     = a1_month_ff[`RTCA_BIT_YEAR_IGN];
  wire       second_alarm_min_ignore     = a2_min_ff[`RTCA_BIT_IGNORE];
  wire       second_alarm_hr_ignore      = a2_hours_ff[`RTCA_BIT_IGNORE];
  wire       second_alarm_pm_or_twenty   = a2_hours_ff[`RTCA_BIT_PM_TWENTY];
  wire       second_alarm_daydate_ignore = a2_daydate_ff[`RTCA_BIT_IGNORE];
  wire       second_alarm_weekday_select = a2_daydate_ff[`RTCA_BIT_WEEKDAY];

  // Compare values; hours bit 6 and month bit 5 are stored as zero anyway.
  wire [6:0] a1_sec_val   = a1_sec_ff[6:0];
  wire [6:0] a1_min_val   = a1_min_ff[6:0];
  wire [5:0] a1_hour_val  = {first_alarm_pm_or_twenty, a1_hours_ff[`RTCA_BIT_HR_TENS:0]};
  wire [5:0] a1_dd_val    = a1_daydate_ff[5:0];
  wire [4:0] a1_month_val = a1_month_ff[`RTCA_BIT_MON_TENS:0];
  wire [7:0] a1_year_val  = a1_year_ff;
  wire [6:0] a2_min_val   = a2_min_ff[6:0];
  wire [5:0] a2_hour_val  = {second_alarm_pm_or_twenty, a2_hours_ff[`RTCA_BIT_HR_TENS:0]};
  wire [5:0] a2_dd_val    = a2_daydate_ff[5:0];

  // ========================================================================
  // Alarm compare
  // Day/date compare target is chosen per alarm by its weekday select bit.
  wire [5:0] a1_dd_time = first_alarm_weekday_select ? {3'h0, time_day} : time_date;
  wire [5:0] a2_dd_time = second_alarm_weekday_select ? {3'h0, time_day} : time_date;
  wire [8:0] hit;

  // Alarm1 fields.
  rtca_field_cmp #(.W(7)) u_a1_sec (
    .alarm_val (a1_sec_val),
    .time_val  (time_sec),
    .ignore    (first_alarm_sec_ignore),
    .hit       (hit[0])
  );

  rtca_field_cmp #(.W(7)) u_a1_min (
    .alarm_val (a1_min_val),
    .time_val  (time_min),
    .ignore    (first_alarm_min_ignore),
    .hit       (hit[1])
  );

  rtca_field_cmp #(.W(6)) u_a1_hr (
    .alarm_val (a1_hour_val),
    .time_val  (time_hour),
    .ignore    (first_alarm_hr_ignore),
    .hit       (hit[2])
  );

  rtca_field_cmp #(.W(6)) u_a1_dd (
    .alarm_val (a1_dd_val),
    .time_val  (a1_dd_time),
    .ignore    (first_alarm_daydate_ignore),
    .hit       (hit[3])
  );

  rtca_field_cmp #(.W(5)) u_a1_mon (
    .alarm_val (a1_month_val),
    .time_val  (time_month),
    .ignore    (first_alarm_month_ignore),
    .hit       (hit[4])
  );

  rtca_field_cmp #(.W(8)) u_a1_yr (
    .alarm_val (a1_year_val),
    .time_val  (time_year),
    .ignore    (first_alarm_year_ignore),
    .hit       (hit[5])
  );

  // Alarm2 fields.
  rtca_field_cmp #(.W(7)) u_a2_min (
    .alarm_val (a2_min_val),
    .time_val  (time_min),
    .ignore    (second_alarm_min_ignore),
    .hit       (hit[6])
  );

  rtca_field_cmp #(.W(6)) u_a2_hr (
    .alarm_val (a2_hour_val),
    .time_val  (time_hour),
    .ignore    (second_alarm_hr_ignore),
    .hit       (hit[7])
  );

  rtca_field_cmp #(.W(6)) u_a2_dd (
    .alarm_val (a2_dd_val),
    .time_val  (a2_dd_time),
    .ignore    (second_alarm_daydate_ignore),
    .hit       (hit[8])
  );

  wire a1_match = &hit[5:0];
  wire a2_match = &hit[8:6];

  // A held match would fire every cycle for a whole time unit, so only the
  // onset is reported.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      a1_match_ff <= 1'b0;
      alarm1_ff   <= 1'b0;
    end else begin
      a1_match_ff <= a1_match;
      alarm1_ff   <= a1_match & ~a1_match_ff;
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      a2_match_ff <= 1'b0;
      alarm2_ff   <= 1'b0;
    end else begin
      a2_match_ff <= a2_match;
      alarm2_ff   <= a2_match & ~a2_match_ff;
    end
  end

  // ========================================================================
  // Countdown
  // Holding the count at the reload value while stopped means that every
  // start runs a full period.
  wire       cnt_at_zero  = (cnt_value_ff == 8'h00);
  wire       cnt_at_one   = (cnt_value_ff == 8'h01);
  wire [7:0] cnt_wrap_val = cnt_repeat ? cnt_reload_ff : 8'h00;

  always @* begin
    nxt_cnt  = cnt_value_ff;
    nxt_zero = 1'b0;
    if (!cnt_enable) begin
      nxt_cnt = cnt_reload_ff;
    end else if (tick) begin
      if (cnt_at_zero) begin
        // A stopped one-shot stays at zero without repeating the pulse.
      end else if (cnt_at_one) begin
        nxt_zero = 1'b1;
        nxt_cnt  = cnt_wrap_val;
      end else begin
        nxt_cnt = cnt_value_ff - 8'h01;
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_value_ff <= `RTCA_RST_COUNT;
      cnt_zero_ff  <= 1'b0;
    end else begin
      cnt_value_ff <= nxt_cnt;
      cnt_zero_ff  <= nxt_zero;
    end
  end

  // ========================================================================
  // Read path
  always @* begin
    case (reg_addr)
      `RTCA_OFS_A1_SEC:     nxt_rdata = a1_sec_ff;
      `RTCA_OFS_A1_MIN:     nxt_rdata = a1_min_ff;
      `RTCA_OFS_A1_HOURS:   nxt_rdata = a1_hours_ff;
      `RTCA_OFS_A1_DAYDATE: nxt_rdata = a1_daydate_ff;
      `RTCA_OFS_A1_MONTH:   nxt_rdata = a1_month_ff;
      `RTCA_OFS_A1_YEAR:    nxt_rdata = a1_year_ff;
      `RTCA_OFS_A2_MIN:     nxt_rdata = a2_min_ff;
      `RTCA_OFS_A2_HOURS:   nxt_rdata = a2_hours_ff;
      `RTCA_OFS_A2_DAYDATE: nxt_rdata = a2_daydate_ff;
      `RTCA_OFS_CNT_VALUE:  nxt_rdata = cnt_value_ff;
      `RTCA_OFS_CNT_RELOAD: nxt_rdata = cnt_reload_ff;
      default:              nxt_rdata = 8'h00;
    endcase
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule
`default_nettype wire

// ---- rtca_regs_monitor.sv ----
// Purpose: Port assertions for the alarm and countdown register slice.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to rtca_regs from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module rtca_regs_monitor (
  input wire logic       sys_clk,      // Clock
  input wire logic       arst_n,       // Reset
  input wire logic [7:0] reg_addr,     // Index
  input wire logic [7:0] reg_wdata,    // Write data
  input wire logic       reg_wr,       // Write strobe
  input wire logic       reg_rd,       // Read strobe
  input wire logic [7:0] reg_rdata_ff, // Read data
  input wire logic       tick,         // Tick
  input wire logic       alarm1_ff,    // Alarm1 pulse
  input wire logic       alarm2_ff,    // Alarm2 pulse
  input wire logic       cnt_zero_ff   // Zero pulse
);
  // ==========================================================================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  chk_a1_one_pulse: assert property (
    alarm1_ff |=> !alarm1_ff) else $error("alarm1 pulse too long");
  chk_a2_one_pulse: assert property (
    alarm2_ff |=> !alarm2_ff) else $error("alarm2 pulse too long");
  chk_zero_one_pulse: assert property (
    cnt_zero_ff |=> !cnt_zero_ff) else $error("zero pulse too long");
  chk_zero_after_tick: assert property (
    cnt_zero_ff |-> $past(tick)) else $error("zero pulse without tick");
  chk_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata_ff)) else $error("read data moved");
  chk_unmapped_zero: assert property (
    reg_rd && (reg_addr < 8'h0F || reg_addr > 8'h19) |=> reg_rdata_ff == 8'h00)
    else $error("unmapped read not zero");
  chk_hours_bit6: assert property (
    reg_rd && (reg_addr == 8'h11 || reg_addr == 8'h16) |=> !reg_rdata_ff[6])
    else $error("hours bit 6 set");
  chk_month_bit5: assert property (
    reg_rd && reg_addr == 8'h13 |=> !reg_rdata_ff[5]) else $error("month bit 5 set");
  chk_reload_back: assert property (
    reg_wr && reg_addr == 8'h19 ##2 reg_rd && reg_addr == 8'h19
    |=> reg_rdata_ff == $past(reg_wdata, 3)) else $error("reload readback wrong");
endmodule
`default_nettype wire

// ---- rtca_host.sv ----
// Purpose: Host model issuing byte register writes and reads.
// Assumes: Each task is entered just after a rising edge.
// Notes:   Each task lets one idle edge pass, so no strobe falls and rises in one step.
`timescale 1ns/10ps
`default_nettype none
module rtca_host (
  input  wire logic       sys_clk,     // Clock
  output var  logic [7:0] reg_addr,    // Index
  output var  logic [7:0] reg_wdata,   // Write data
  output var  logic       reg_wr,      // Write strobe
  output var  logic       reg_rd,      // Read strobe
  input  wire logic [7:0] reg_rdata_ff // Read data
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  // Data is taken just after the edge that samples the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata_ff;
    @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- rtca_regs_tb.sv ----
// Purpose: Self-checking bench for the alarm and countdown registers.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Pulses are counted by a clocked process.
`timescale 1ns/10ps
`default_nettype none
module rtca_regs_tb;
  logic       sys_clk = 1'b0, arst_n = 1'b0, tick = 1'b0, cnt_enable = 1'b0;
  logic       cnt_repeat = 1'b0, reg_wr, reg_rd, alarm1_ff, alarm2_ff, cnt_zero_ff;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_ff, v, time_year = 8'h24;
  logic [6:0] time_sec = 7'h00, time_min = 7'h00;
  logic [5:0] time_hour = 6'h32, time_date = 6'h15;
  logic [4:0] time_month = 5'h12;
  logic [2:0] time_day = 3'h3;
  int         mismatches = 0, cmp_count = 0, a1_n = 0, a2_n = 0, z_n = 0, a1_s, a2_s, z_s;
  rtca_regs DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_ff, .time_sec, .time_min, .time_hour, .time_day, .time_date,
    .time_month, .time_year, .tick, .cnt_enable, .cnt_repeat, .alarm1_ff,
    .alarm2_ff, .cnt_zero_ff);
  rtca_host host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    a1_n += (alarm1_ff === 1'b1);
    a2_n += (alarm2_ff === 1'b1);
    z_n += (cnt_zero_ff === 1'b1);
  end
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic watch(input int n);
    a1_s = a1_n;
    a2_s = a2_n;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic pulse_tick(input int n);
    repeat (n) begin
      tick = 1'b1;
      @(posedge sys_clk);
      #1 tick = 1'b0;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    for (int a = 8'h0F; a <= 8'h19; a++) begin
      host.rd(8'(a), v);
      chk(v, 8'h00);
    end
  endtask
  // Only stuck-low bits show here; the alarm scenario proves the fields work.
  task automatic t_fields;
    logic [7:0] e;
    for (int a = 8'h0F; a <= 8'h1A; a++) begin
      e = (a == 8'h11 || a == 8'h16) ? 8'hBF : (a == 8'h13) ? 8'hDF : 8'hFF;
      host.wr(8'(a), 8'hFF);
      host.rd(8'(a), v);
      chk(v, (a == 8'h18 || a == 8'h1A) ? 8'h00 : e);
    end
  endtask
  task automatic t_alarm;
    logic [7:0] av [9] = '{8'h80, 8'h45, 8'h32, 8'h15, 8'h12, 8'h24, 8'h45, 8'h32, 8'h43};
    for (int i = 0; i < 9; i++) host.wr(8'(8'h0F + i), av[i]);
    watch(2);
    time_min = 7'h45;
    watch(4);
    chk(8'(a1_n - a1_s), 8'h01);
    chk(8'(a2_n - a2_s), 8'h01);
    time_min = 7'h00;
    time_year = 8'h99;
    watch(2);
    time_min = 7'h45;
    watch(4);
    chk(8'(a1_n - a1_s), 8'h00);
    chk(8'(a2_n - a2_s), 8'h01);
    host.wr(8'h13, 8'h52);
    watch(4);
    chk(8'(a1_n - a1_s), 8'h01);
    chk(8'(a2_n - a2_s), 8'h00);
    host.wr(8'h0F, 8'h30);
    watch(2);
    time_sec = 7'h30;
    watch(4);
    chk(8'(a1_n - a1_s), 8'h01);
  endtask
  task automatic t_count;
    host.wr(8'h19, 8'h03);
    host.rd(8'h19, v);
    chk(v, 8'h03);
    host.rd(8'h18, v);
    chk(v, 8'h03);
    cnt_enable = 1'b1;
    cnt_repeat = 1'b1;
    z_s = z_n;
    pulse_tick(3);
    host.rd(8'h18, v);
    chk(v, 8'h03);
    chk(8'(z_n - z_s), 8'h01);
    cnt_repeat = 1'b0;
    pulse_tick(3);
    host.rd(8'h18, v);
    chk(v, 8'h00);
    chk(8'(z_n - z_s), 8'h02);
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    t_reset;
    t_fields;
    t_alarm;
    t_count;
    end_of_test;
  end
  initial begin
    #75000;
    mismatches++;
    end_of_test;
  end
endmodule
bind rtca_regs rtca_regs_monitor u_mon (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata_ff, .tick, .alarm1_ff, .alarm2_ff, .cnt_zero_ff);
`default_nettype wire
